// >>> pcb_cfg_bridge.sv
`default_nettype none
module pcb_cfg_bridge (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    ce_in,
  input  wire logic [1:0]              strap_id_in,
  input  wire logic                    io_req_in,
  input  wire logic                    io_wr_in,
  input  wire logic [13:0]             io_word_addr_in,
  input  wire logic [3:0]              io_be_in,
  input  wire logic [31:0]             io_wdata_in,
  output logic                         io_ack_out,
  output logic      [31:0]             io_rdata_out,
  output pcb_pkg::pcb_cfg_cyc_type     cfg_cyc_out,
  input  wire logic                    cfg_done_in,
  input  wire logic                    cfg_mabort_in,
  input  wire logic [31:0]             cfg_rdata_in,
  output logic                         cpu_reset_out,
  output logic                         cpu_init_out,
  output logic                         deturbo_out,
  output logic      [4:0]              dev_num_out,
  output logic      [3:0]              agent_id_out
);
  // ==========================================================================
  // state and helpers
  pcb_pkg::pcb_state_type st_q;
  pcb_pkg::pcb_state_type st_d;
  logic        int_wr;
  logic [31:0] int_rdata;
  logic [7:0]  bridge_bus;
  logic [7:0]  sub_bus;
  logic [7:0]  f_bus;
  logic [4:0]  f_dev;
  logic [2:0]  f_func;
  logic [5:0]  f_reg;
  logic        hit_caddr;
  logic        hit_trc;
  logic        hit_cdata;
  logic        own_dev;
  logic        host_agent;
  logic        do_type0;
  logic        do_type1;
  logic [7:0]  trc_new;

  // ==========================================================================
  // address window fields, taken apart once
  assign f_bus  = st_q.caddr[pcb_pkg::BUS_LSB +: 8];
  assign f_dev  = st_q.caddr[pcb_pkg::DEV_LSB +: 5];
  assign f_func = st_q.caddr[pcb_pkg::FUNC_LSB +: 3];
  assign f_reg  = st_q.caddr[pcb_pkg::REG_LSB +: 6];

  // ==========================================================================
  // i/o decode: cf8 needs all four lanes, so on the compatible bridge a partial access there that enables lane 1 falls to cf9
  assign hit_caddr = (io_word_addr_in == pcb_pkg::WORD_CONF_ADDR) &&
                     (io_be_in == pcb_pkg::BE_DWORD);
  assign hit_trc   = (io_word_addr_in == pcb_pkg::WORD_CONF_ADDR) && !hit_caddr &&
                     io_be_in[pcb_pkg::TRC_LANE] && st_q.compat;
  assign hit_cdata = (io_word_addr_in == pcb_pkg::WORD_CONF_DATA) &&
                     st_q.caddr[pcb_pkg::CSE_BIT];

  // target decode; own registers pinned to bus 0 regardless of bridge bus
  assign own_dev    = (f_bus == pcb_pkg::BUS_ZERO) && (f_dev == st_q.dev_num);
  assign host_agent = (f_bus == pcb_pkg::BUS_ZERO) && !own_dev &&
                      (f_dev >= pcb_pkg::HOST_DEV_MIN) &&
                      (f_dev <= pcb_pkg::HOST_DEV_MAX);
  assign do_type0   = (f_dev <= pcb_pkg::PCI_DEV_MAX) &&
                      ((f_bus == bridge_bus) ||
                       ((f_bus == pcb_pkg::BUS_ZERO) && st_q.compat));
  assign do_type1   = (f_bus > bridge_bus) && (f_bus <= sub_bus);

  // turbo/reset byte as it would read after the write, reserved bits dropped
  assign trc_new = io_wdata_in[8*pcb_pkg::TRC_LANE +: 8] & pcb_pkg::TRC_MASK;

  // internal register write strobe, only for function 0 of own device
  assign int_wr = ce_in && io_req_in && io_wr_in && (st_q.acc_st == pcb_pkg::ACC_IDLE) &&
                  hit_cdata && own_dev && (f_func == pcb_pkg::FUNC_ZERO);

  // ==========================================================================
  // bus number registers reached through the internal path
  pcb_busreg u_busreg (
    .sys_clk_in  (sys_clk_in),
    .rst_b_in    (rst_b_in),
    .ce_in       (ce_in),
    .wr_in       (int_wr),
    .reg_sel_in  (f_reg),
    .be_in       (io_be_in),
    .wdata_in    (io_wdata_in),
    .dev_num_in  (st_q.dev_num),
    .rdata_out   (int_rdata),
    .bus_num_out (bridge_bus),
    .sub_num_out (sub_bus)
  );

  // ==========================================================================
  // next state: access engine, cpu reset sequencer, strap capture
  always_comb begin
    st_d     = st_q;
    st_d.ack = 1'b0;

    // strap sampled once, on the first enabled cycle after reset release
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.compat     = (strap_id_in != pcb_pkg::STRAP_ID_AUX);
      st_d.dev_num    = pcb_pkg::dev_of_strap(strap_id_in);
      st_d.agent_id   = pcb_pkg::agent_of_strap(strap_id_in);
    end

    case (st_q.acc_st)
      pcb_pkg::ACC_IDLE: begin
        if (io_req_in && hit_caddr) begin
          // auxiliary bridge stores writes silently and never answers
          if (io_wr_in) begin
            st_d.caddr = io_wdata_in & pcb_pkg::CONF_ADDR_MASK;
          end
          st_d.ack   = st_q.compat;
          st_d.rdata = st_q.caddr;
        end else if (io_req_in && hit_trc) begin
          if (io_wr_in) begin
            st_d.turbo_reset_control = trc_new;
            // type bits are read from the same write, not from the value software set before
            if (trc_new[pcb_pkg::TRC_RESET] && !st_q.turbo_reset_control[pcb_pkg::TRC_RESET] &&
                (st_q.rst_st == pcb_pkg::RST_IDLE)) begin
              st_d.rst_cnt = 16'h0000;
              if (trc_new[pcb_pkg::TRC_BIST] || trc_new[pcb_pkg::TRC_HARD]) begin
                st_d.rst_st    = pcb_pkg::RST_HARD;
                st_d.cpu_reset = 1'b1;
                st_d.cpu_init  = trc_new[pcb_pkg::TRC_BIST];
              end else begin
                st_d.rst_st   = pcb_pkg::RST_SOFT;
                st_d.cpu_init = 1'b1;
              end
            end
          end
          st_d.ack   = 1'b1;
          st_d.rdata = {16'h0000, st_q.turbo_reset_control, 8'h00};
        end else if (io_req_in && hit_cdata) begin
          if (own_dev && (f_func == pcb_pkg::FUNC_ZERO)) begin
            st_d.ack   = 1'b1;
            st_d.rdata = int_rdata;
          end else if (own_dev || (!host_agent && (do_type0 || do_type1))) begin
            // only config read/write cycles are built; no special cycles
            st_d.acc_st    = pcb_pkg::ACC_PCI;
            st_d.cfg.req   = 1'b1;
            st_d.cfg.wr    = io_wr_in;
            st_d.cfg.be    = io_be_in;
            st_d.cfg.wdata = io_wdata_in;
            st_d.cfg.type1 = !own_dev && !do_type0;
            if (own_dev) begin
              // idsel-less type 0: nobody decodes it, the cycle master-aborts
              st_d.cfg.addr = {16'h0000, 5'h00, f_func, f_reg, 2'h0};
            end else if (do_type0) begin
              st_d.cfg.addr = {16'h0001 << f_dev[3:0], 5'h00, f_func, f_reg,
                               2'h0};
            end else begin
              st_d.cfg.addr = {8'h00, f_bus, f_dev, f_func, f_reg,
                               pcb_pkg::PCI_TYPE1_CODE};
            end
          end
          // host agents and unmapped buses are left to their own responders
        end
      end
      pcb_pkg::ACC_PCI: begin
        if (cfg_done_in) begin
          st_d.acc_st  = pcb_pkg::ACC_IDLE;
          st_d.cfg.req = 1'b0;
          st_d.ack     = 1'b1;
          st_d.rdata   = cfg_mabort_in ? 32'hFFFF_FFFF : cfg_rdata_in;
        end
      end
      default: begin
        st_d.acc_st = pcb_pkg::ACC_IDLE;
      end
    endcase

    // cpu reset sequencer; counts are fixed cycle figures, not ce-scaled
    case (st_q.rst_st)
      pcb_pkg::RST_HARD: begin
        st_d.rst_cnt = st_q.rst_cnt + 16'h0001;
        if (st_q.rst_cnt == 16'(pcb_pkg::HARD_PULSE_CYC - 1)) begin
          st_d.rst_cnt   = 16'h0000;
          st_d.cpu_reset = 1'b0;
          // with self-test the init line outlives the reset line
          st_d.rst_st    = st_q.cpu_init ? pcb_pkg::RST_BIST_INIT : pcb_pkg::RST_IDLE;
        end
      end
      pcb_pkg::RST_BIST_INIT: begin
        st_d.rst_cnt = st_q.rst_cnt + 16'h0001;
        if (st_q.rst_cnt == 16'(pcb_pkg::BIST_HOLD_CYC - 1)) begin
          st_d.cpu_init = 1'b0;
          st_d.rst_st   = pcb_pkg::RST_IDLE;
        end
      end
      pcb_pkg::RST_SOFT: begin
        st_d.rst_cnt = st_q.rst_cnt + 16'h0001;
        if (st_q.rst_cnt == 16'(pcb_pkg::SOFT_PULSE_CYC - 1)) begin
          st_d.cpu_init = 1'b0;
          st_d.rst_st   = pcb_pkg::RST_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  // ==========================================================================
  // state register; ce low freezes everything
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      st_q.acc_st     <= pcb_pkg::ACC_IDLE;
      st_q.rst_st     <= pcb_pkg::RST_IDLE;
      st_q.caddr      <= pcb_pkg::CONF_ADDR_RST;
      st_q.turbo_reset_control        <= pcb_pkg::TRC_RST_VAL;
      st_q.strap_done <= 1'b0;
      st_q.compat     <= 1'b1;
      st_q.dev_num    <= pcb_pkg::DEV_COMPAT;
      st_q.agent_id   <= pcb_pkg::AGENT_COMPAT;
      st_q.rst_cnt    <= 16'h0000;
      st_q.ack        <= 1'b0;
      st_q.rdata      <= 32'h0000_0000;
      st_q.cpu_reset  <= 1'b0;
      st_q.cpu_init   <= 1'b0;
      st_q.cfg        <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign io_ack_out    = st_q.ack;
  assign io_rdata_out  = st_q.rdata;
  assign cfg_cyc_out   = st_q.cfg;
  assign cpu_reset_out = st_q.cpu_reset;
  assign cpu_init_out  = st_q.cpu_init;
  assign deturbo_out   = st_q.turbo_reset_control[pcb_pkg::TRC_DETURBO];  // software clears it first
  assign dev_num_out   = st_q.dev_num;
  assign agent_id_out  = st_q.agent_id;

  // ==========================================================================
  // checks on the driven side
  a_func_on_ad: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    st_q.cfg.req |-> st_q.cfg.addr[10:8] == f_func)
    else $error("function field not on AD[10:8]");

  a_reg_on_ad: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    st_q.cfg.req |-> st_q.cfg.addr[7:2] == f_reg)
    else $error("register field not on AD[7:2]");

  a_type0_idsel: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (st_q.cfg.req && !st_q.cfg.type1 && !own_dev) |->
      (st_q.cfg.addr[31:16] == (16'h0001 << f_dev[3:0])) && (f_dev <= 5'h0F))
    else $error("type 0 idsel line wrong");

  a_type1_map: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (st_q.cfg.req && st_q.cfg.type1) |->
      st_q.cfg.addr[23:16] == f_bus && st_q.cfg.addr[15:11] == f_dev &&
      st_q.cfg.addr[1:0] == 2'h1 && st_q.cfg.addr[31:24] == 8'h00)
    else $error("type 1 address mapping wrong");

  a_reset_edge: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ($stable(st_q.turbo_reset_control[pcb_pkg::TRC_RESET]) && st_q.rst_st == pcb_pkg::RST_IDLE) |=>
      st_q.rst_st == pcb_pkg::RST_IDLE || $rose(st_q.turbo_reset_control[pcb_pkg::TRC_RESET]))
    else $error("cpu reset started without a 0 to 1 change");

  a_bist_init: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $fell(cpu_reset_out) && cpu_init_out |->
      cpu_init_out [*8] ##1 (st_q.rst_st == pcb_pkg::RST_BIST_INIT || !ce_in))
    else $error("init not held after reset release");

  a_soft_kind: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ($rose(st_q.turbo_reset_control[pcb_pkg::TRC_RESET]) && st_q.rst_st != pcb_pkg::RST_IDLE) |->
      (cpu_reset_out == (st_q.turbo_reset_control[pcb_pkg::TRC_HARD] || st_q.turbo_reset_control[pcb_pkg::TRC_BIST])) &&
      (cpu_init_out == !cpu_reset_out || st_q.turbo_reset_control[pcb_pkg::TRC_BIST]))
    else $error("reset kind does not follow the type bits");

  a_internal_nopci: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && io_req_in && st_q.acc_st == pcb_pkg::ACC_IDLE && hit_cdata && own_dev &&
     f_func == 3'h0) |=> io_ack_out && !st_q.cfg.req)
    else $error("internal access made a pci cycle");

  a_cse_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (ce_in && io_req_in && st_q.acc_st == pcb_pkg::ACC_IDLE && !st_q.cfg.req &&
     io_word_addr_in == pcb_pkg::WORD_CONF_DATA && !st_q.caddr[31]) |=>
      !io_ack_out && !st_q.cfg.req)
    else $error("data window used while disabled");
endmodule
`default_nettype wire

// >>> pcb_pkg.sv
`default_nettype none
package pcb_pkg;
  // ==========================================================================
  // i/o space map (byte addresses as decoded on the host i/o port)
  localparam logic [15:0] IO_CONF_ADDR   = 16'h0CF8;
  localparam logic [15:0] IO_TURBO_RST   = 16'h0CF9;
  localparam logic [15:0] IO_CONF_DATA   = 16'h0CFC;
  localparam logic [13:0] WORD_CONF_ADDR = IO_CONF_ADDR[15:2];
  localparam logic [13:0] WORD_CONF_DATA = IO_CONF_DATA[15:2];
  localparam int          TRC_LANE       = 1;     // cf9 sits in byte lane 1
  localparam logic [3:0]  BE_DWORD       = 4'hF;

  // ==========================================================================
  // address window fields
  localparam int          CSE_BIT        = 31;
  localparam int          BUS_LSB        = 16;
  localparam int          DEV_LSB        = 11;
  localparam int          FUNC_LSB       = 8;
  localparam int          REG_LSB        = 2;
  localparam logic [31:0] CONF_ADDR_MASK = 32'h80FF_FFFC;
  localparam logic [31:0] CONF_ADDR_RST  = 32'h0000_0000;
  localparam logic [1:0]  PCI_TYPE1_CODE = 2'h1;

  // ==========================================================================
  // turbo and reset control fields
  localparam int          TRC_DETURBO    = 0;
  localparam int          TRC_HARD       = 1;
  localparam int          TRC_RESET      = 2;
  localparam int          TRC_BIST       = 3;
  localparam logic [7:0]  TRC_MASK       = 8'h0F;
  localparam logic [7:0]  TRC_RST_VAL    = 8'h00;

  // ==========================================================================
  // device numbering on bus 0
  localparam logic [1:0]  STRAP_ID_COMPAT = 2'h1;
  localparam logic [1:0]  STRAP_ID_AUX    = 2'h2;
  localparam logic [4:0]  DEV_COMPAT      = 5'h19;  // 11001
  localparam logic [4:0]  DEV_AUX         = 5'h1A;  // 11010
  localparam logic [3:0]  AGENT_COMPAT    = 4'h9;   // 1001
  localparam logic [3:0]  AGENT_AUX       = 4'hA;   // 1010
  localparam logic [4:0]  PCI_DEV_MAX     = 5'h0F;
  localparam logic [4:0]  HOST_DEV_MIN    = 5'h10;
  localparam logic [4:0]  HOST_DEV_MAX    = 5'h1E;
  localparam logic [7:0]  BUS_ZERO        = 8'h00;
  localparam logic [2:0]  FUNC_ZERO       = 3'h0;

  // ==========================================================================
  // internal bus number registers (dword 12h: bytes 4ah, 4bh; byte 49h reads the device number)
  localparam logic [5:0]  BUSREG_SEL      = 6'h12;
  localparam logic [7:0]  BUS_NUM_RST     = 8'h00;

  // ==========================================================================
  // cpu reset timing
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned HARD_PULSE_NS   = 1000;
  localparam int unsigned SOFT_PULSE_NS   = 100;
  localparam int unsigned BIST_HOLD_NS    = 200;
  localparam int unsigned HARD_PULSE_CYC  = (HARD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_PULSE_CYC  = (SOFT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BIST_HOLD_CYC   = (BIST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {ACC_IDLE, ACC_PCI} pcb_acc_state_type;
  typedef enum logic [1:0] {RST_IDLE, RST_HARD, RST_SOFT, RST_BIST_INIT} pcb_rst_state_type;

  typedef struct packed {
    logic        req;
    logic        type1;
    logic        wr;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pcb_cfg_cyc_type;

  typedef struct packed {
    pcb_acc_state_type acc_st;
    pcb_rst_state_type rst_st;
    logic [31:0]       caddr;
    logic [7:0]        turbo_reset_control;
    logic              strap_done;
    logic              compat;
    logic [4:0]        dev_num;
    logic [3:0]        agent_id;
    logic [15:0]       rst_cnt;
    logic              ack;
    logic [31:0]       rdata;
    logic              cpu_reset;
    logic              cpu_init;
    pcb_cfg_cyc_type   cfg;
  } pcb_state_type;

  typedef struct packed {
    logic [7:0] bus_num;
    logic [7:0] sub_num;
  } pcb_busreg_type;

  // ==========================================================================
  // strap decode, used for device number and agent id
  function automatic logic [4:0] dev_of_strap(input logic [1:0] id);
    dev_of_strap = (id == STRAP_ID_AUX) ? DEV_AUX : DEV_COMPAT;
  endfunction

  function automatic logic [3:0] agent_of_strap(input logic [1:0] id);
    agent_of_strap = (id == STRAP_ID_AUX) ? AGENT_AUX : AGENT_COMPAT;
  endfunction

  // byte-enable merge of one 8-bit lane
  function automatic logic [7:0] merge_lane(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic en);
    merge_lane = en ? new_v : old_v;
  endfunction
endpackage
`default_nettype wire

// >>> pcb_busreg.sv
`default_nettype none
module pcb_busreg (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        wr_in,
  input  wire logic [5:0]  reg_sel_in,
  input  wire logic [3:0]  be_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [4:0]  dev_num_in,
  output logic      [31:0] rdata_out,
  output logic      [7:0]  bus_num_out,
  output logic      [7:0]  sub_num_out
);
  // ==========================================================================
  // state
  pcb_pkg::pcb_busreg_type st_q;
  pcb_pkg::pcb_busreg_type st_d;

  // only the lanes whose enables are set change
  always_comb begin
    st_d = st_q;
    if (wr_in && (reg_sel_in == pcb_pkg::BUSREG_SEL)) begin
      st_d.bus_num = pcb_pkg::merge_lane(st_q.bus_num, wdata_in[23:16], be_in[2]);
      st_d.sub_num = pcb_pkg::merge_lane(st_q.sub_num, wdata_in[31:24], be_in[3]);
    end
  end

  // bus number comes up as zero
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      st_q.bus_num <= pcb_pkg::BUS_NUM_RST;
      st_q.sub_num <= pcb_pkg::BUS_NUM_RST;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  // read mux: other internal dwords are not kept here and read zero
  always_comb begin
    rdata_out = 32'h0000_0000;
    if (reg_sel_in == pcb_pkg::BUSREG_SEL) begin
      rdata_out = {st_q.sub_num, st_q.bus_num, 3'h0, dev_num_in, 8'h00};
    end
  end

  assign bus_num_out = st_q.bus_num;
  assign sub_num_out = st_q.sub_num;
endmodule
`default_nettype wire

// >>> pcb_pci_model.sv
`default_nettype none
module pcb_pci_model (
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_b_in,
  input  wire logic                     slow_in,
  input  wire pcb_pkg::pcb_cfg_cyc_type cyc_in,
  output logic                          done_out,
  output logic                          mabort_out,
  output logic [31:0]                   rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // pci engine: answers after 1 or 9 cycles, returns the address phase with A5A5 xored into its upper half as data
  logic [3:0] wait_q;
  always_ff @(posedge sys_clk_in) begin
    done_out <= 1'b0;
    rdata_out <= ~rdata_out; // no stale data between answers
    if (!rst_b_in || !cyc_in.req || done_out) begin
      wait_q <= slow_in ? 4'h8 : 4'h0;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else begin
      done_out <= 1'b1;
      // type 0 without any device select line finds no target
      mabort_out <= !cyc_in.type1 && cyc_in.addr[31:16] == 16'h0000;
      rdata_out <= cyc_in.addr ^ 32'hA5A5_0000;
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] CA = pcb_pkg::WORD_CONF_ADDR;
  localparam logic [13:0] CD = pcb_pkg::WORD_CONF_DATA;
  logic clk, rst_b, req, wr, slow, ack, crst, cini, detb, done, mab;
  logic [13:0] wa;
  logic [3:0] be, agent;
  logic [4:0] dev, d;
  logic [31:0] wd, rd, prd, lfsr, e;
  logic [63:0] nt;
  pcb_pkg::pcb_cfg_cyc_type cyc;
  logic [63:0] notes[$]; // {mask, expected read data}
  int n_fail, samples_checked, cyc_cnt;
  pcb_cfg_bridge dut_u (.sys_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .strap_id_in(2'h1),
    .io_req_in(req), .io_wr_in(wr), .io_word_addr_in(wa), .io_be_in(be), .io_wdata_in(wd),
    .io_ack_out(ack), .io_rdata_out(rd), .cfg_cyc_out(cyc), .cfg_done_in(done),
    .cfg_mabort_in(mab), .cfg_rdata_in(prd), .cpu_reset_out(crst), .cpu_init_out(cini),
    .deturbo_out(detb), .dev_num_out(dev), .agent_id_out(agent));
  pcb_pci_model pci_u (.sys_clk_in(clk), .rst_b_in(rst_b), .slow_in(slow), .cyc_in(cyc),
    .done_out(done), .mabort_out(mab), .rdata_out(prd));
  // ==========================================================================
  // checking helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one host request; an answer that never comes is caught after 30 cycles
  task automatic io(input logic w, input logic [13:0] a, input logic [3:0] b,
                    input logic [31:0] dt, input logic [63:0] n, input bit ea);
    @(negedge clk);
    {req, wr, wa, be, wd} = {1'b1, w, a, b, dt};
    if (ea) notes.push_back(n);
    @(negedge clk);
    {req, wd} = {1'b0, ~dt};
    repeat (30) @(negedge clk);
    if (notes.size() != 0) begin
      chk(32'h0, 32'h1);
      notes.delete();
    end
  endtask
  task automatic cr(input logic [31:0] ca, input logic [63:0] n, input bit ea);
    io(1'b1, CA, 4'hF, ca, 64'h0, 1'b1);
    io(1'b0, CD, 4'hF, 32'h0, n, ea);
  endtask
  task automatic tr(input logic [7:0] v, input int n_rst, input int n_ini);
    int a, b;
    // counting starts with the request, so the whole pulse is seen
    @(negedge clk);
    {req, wr, wa, be, wd} = {1'b1, 1'b1, CA, 4'h2, {16'h0, v, 8'h00}};
    notes.push_back(64'h0);
    {a, b} = 0;
    repeat (400) @(negedge clk) begin
      req = 1'b0;
      a += int'(crst === 1'b1);
      b += int'(cini === 1'b1);
    end
    chk(a, n_rst);
    chk(b, n_ini);
  endtask
  // ==========================================================================
  // clock, watchdog and answer monitor
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // outputs are looked at mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      wrap_up();
    end
    if (ack === 1'b1) begin
      if (notes.size() == 0) chk(32'h0, 32'h1);
      else begin
        nt = notes.pop_front();
        chk(rd & nt[63:32], nt[31:0]);
      end
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    {rst_b, req, wr, slow, wa, be, wd, lfsr} = {4'h0, 14'h0, 4'h0, 32'h0, 32'h450AFD73};
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    chk({23'h0, dev, agent}, {23'h0, 5'h19, 4'h9});
    repeat (4) begin
      lfsr = nxt(lfsr);
      io(1'b1, CA, 4'hF, lfsr, 64'h0, 1'b1);
      io(1'b0, CA, 4'hF, 32'h0, {32'hFFFFFFFF, lfsr & pcb_pkg::CONF_ADDR_MASK}, 1'b1);
    end
    io(1'b1, CA, 4'h1, 32'h0, 64'h0, 1'b0);
    io(1'b0, CA, 4'hF, 32'h0, {32'hFFFFFFFF, lfsr & pcb_pkg::CONF_ADDR_MASK}, 1'b1);
    cr(32'h8000_C848, {32'hFFFFFF00, 32'h0000_1900}, 1'b1);
    io(1'b1, CD, 4'hC, 32'h0502_0000, 64'h0, 1'b1);
    io(1'b1, CD, 4'h4, 32'hEE03_0000, 64'h0, 1'b1);
    cr(32'h8000_C848, {32'hFFFFFF00, 32'h0503_1900}, 1'b1);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      slow = lfsr[12];
      d = (i % 2 == 0) ? 5'h00 : 5'h0F;
      e = (32'h1 << (16 + d)) | {21'h0, lfsr[10:8], lfsr[5:0], 2'b00};
      cr({8'h80, 8'h03, d, lfsr[10:8], lfsr[5:0], 2'b00}, {32'hFFFFFFFF, e ^ 32'hA5A5_0000}, 1'b1);
    end
    e = {8'h0, 8'h04, 5'h07, 3'h2, 6'h05, 2'b01} ^ 32'hA5A5_0000;
    cr(32'h8004_3A14, {32'hFFFFFFFF, e}, 1'b1);
    cr(32'h8000_CB48, {32'hFFFFFFFF, 32'hFFFFFFFF}, 1'b1);
    cr(32'h8006_3A14, 64'h0, 1'b0);
    cr(32'h8000_A000, 64'h0, 1'b0);
    cr(32'h0003_0800, 64'h0, 1'b0);
    tr(8'h01, 0, 0);
    chk({31'h0, detb}, 32'h1);
    tr(8'h02, 0, 0);
    tr(8'h06, 250, 0);
    tr(8'h06, 0, 0);
    tr(8'h0A, 0, 0);
    tr(8'h0E, 250, 300);
    tr(8'h00, 0, 0);
    tr(8'h04, 0, 25);
    wrap_up();
  end
endmodule
`default_nettype wire
